// >>> hw/rtc_pin_trim_pkg.sv
// Constants, register layouts and types for the output pin and trim block
package rtc_pin_trim_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PIN_CLOCK_CONFIG = 8'h07;
  localparam logic [7:0] ADDR_CLOCK_CORRECTION = 8'h08;
  localparam logic [7:0] ADDR_ALARM0_DAY       = 8'h0d;
  localparam logic [7:0] ADDR_ALARM1_DAY       = 8'h14;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PIN_CLOCK_CONFIG = 8'h80;
  localparam logic [7:0] RST_CLOCK_CORRECTION = 8'h00;
  localparam logic [7:0] RST_ALARM_DAY        = 8'h00;
  localparam int         POS_ALARM_POLARITY   = 7;
  localparam int         POS_ALARM_FLAG       = 3;

  // ---------------------------------------------------------------
  // Timing chain figures: rates in Hz, trim step in oscillator cycles
  // ---------------------------------------------------------------
  localparam int OSC_FREQ_HZ     = 32768;
  localparam int COARSE_RATE_HZ  = 128;
  localparam int SECS_PER_MINUTE = 60;
  localparam int CYCLES_PER_STEP = 2;

  // Pin control fields, most significant first
  typedef struct packed {
    logic       gpo_level;
    logic       square_wave_enable;
    logic       alarm1_enable;
    logic       alarm0_enable;
    logic       external_clock_input_enable;
    logic       coarse_trim_enable;
    logic [1:0] square_wave_freq_select;
  } pin_clock_config_t;

  // Trim register fields
  typedef struct packed {
    logic       trim_add;
    logic [6:0] trim_step_count;
  } clock_correction_t;

  // Pin modes, Gray ordered
  typedef enum logic [1:0] {
    MODE_GPO   = 2'b00,
    MODE_ALARM = 2'b01,
    MODE_SQW   = 2'b11
  } pin_mode_t;

endpackage : rtc_pin_trim_pkg

// >>> hw/sync_two_flop.sv
// Two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : sync_two_flop

// >>> hw/rtc_output_pin_and_trim.sv
// Multi-function pin selection, alarm flags and digital trim of the timing chain
`timescale 1ns/1ps
module rtc_output_pin_and_trim
  import rtc_pin_trim_pkg::*;
#(
  parameter int SECS_PER_MIN = SECS_PER_MINUTE
) (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       osc_clk_i,
  input  wire logic       on_backup_i,
  input  wire logic       alarm0_match_i,
  input  wire logic       alarm1_match_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            ext_clk_enable_o,
  output logic            sec_tick_o,
  output logic            multi_function_pin_o,
  output logic            multi_function_pin_oe_o
);

  // ---------------------------------------------------------------
  // Synchronised pins
  // ---------------------------------------------------------------
  logic [1:0] pins_s;
  logic       osc_s;
  logic       backup_s;

  sync_two_flop #(.WIDTH(2)) u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .async_i   ({on_backup_i, osc_clk_i}),
    .sync_o    (pins_s)
  );

  assign osc_s    = pins_s[0];
  assign backup_s = pins_s[1];

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  pin_clock_config_t cfg_q,  cfg_d;
  clock_correction_t corr_q, corr_d;
  logic [7:0]        day0_q, day0_d;
  logic [7:0]        day1_q, day1_d;
  logic              pol_q,  pol_d;
  logic              flag0_q, flag0_d;
  logic              flag1_q, flag1_d;
  logic [7:0]        rdata_q, rdata_d;
  logic              wr_day0;
  logic              wr_day1;

  assign wr_day0 = reg_wr_i && (reg_addr_i == ADDR_ALARM0_DAY);
  assign wr_day1 = reg_wr_i && (reg_addr_i == ADDR_ALARM1_DAY);

  // Writes, flag updates and read data
  always_comb begin
    cfg_d   = cfg_q;
    corr_d  = corr_q;
    day0_d  = day0_q;
    day1_d  = day1_q;
    pol_d   = pol_q;
    rdata_d = rdata_q;
    if (reg_wr_i && reg_addr_i == ADDR_PIN_CLOCK_CONFIG) begin
      cfg_d = pin_clock_config_t'(reg_wdata_i);
    end
    if (reg_wr_i && reg_addr_i == ADDR_CLOCK_CORRECTION) begin
      corr_d = clock_correction_t'(reg_wdata_i);
    end
    if (wr_day0) begin
      day0_d = reg_wdata_i;
      pol_d  = reg_wdata_i[POS_ALARM_POLARITY];
    end
    if (wr_day1) begin
      day1_d = reg_wdata_i;
      pol_d  = reg_wdata_i[POS_ALARM_POLARITY];
    end
    // A write to its own day register clears the flag, a written one is ignored, a match wins
    flag0_d = alarm0_match_i || (flag0_q && !wr_day0);
    flag1_d = alarm1_match_i || (flag1_q && !wr_day1);
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_PIN_CLOCK_CONFIG: rdata_d = cfg_q;
        ADDR_CLOCK_CORRECTION: rdata_d = corr_q;
        ADDR_ALARM0_DAY:       rdata_d = {pol_q, day0_q[6:4], flag0_q, day0_q[2:0]};
        ADDR_ALARM1_DAY:       rdata_d = {pol_q, day1_q[6:4], flag1_q, day1_q[2:0]};
        default:               rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cfg_q   <= pin_clock_config_t'(RST_PIN_CLOCK_CONFIG);
      corr_q  <= clock_correction_t'(RST_CLOCK_CORRECTION);
      day0_q  <= RST_ALARM_DAY;
      day1_q  <= RST_ALARM_DAY;
      pol_q   <= RST_ALARM_DAY[POS_ALARM_POLARITY];
      flag0_q <= RST_ALARM_DAY[POS_ALARM_FLAG];
      flag1_q <= RST_ALARM_DAY[POS_ALARM_FLAG];
      rdata_q <= 8'h00;
    end else begin
      cfg_q   <= cfg_d;
      corr_q  <= corr_d;
      day0_q  <= day0_d;
      day1_q  <= day1_d;
      pol_q   <= pol_d;
      flag0_q <= flag0_d;
      flag1_q <= flag1_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o      = rdata_q;
  assign ext_clk_enable_o = cfg_q.external_clock_input_enable;

  // ---------------------------------------------------------------
  // Trimmed timing chain
  // ---------------------------------------------------------------
  logic        osc_prev_q, osc_prev_d;
  logic        osc_rise;
  logic [14:0] chain_q, chain_d;
  logic [5:0]  secs_q,  secs_d;
  logic [7:0]  pend_q,  pend_d;
  logic        add_q,   add_d;
  logic        tick_q,  tick_d;
  logic [15:0] chain_sum;
  logic [1:0]  step;
  logic        sec_wrap;
  logic        min_wrap;
  logic        coarse_ev;
  logic        trim_ev;

  assign osc_rise = osc_s && !osc_prev_q;

  // Chain advance with inserted or swallowed cycles
  always_comb begin
    osc_prev_d = osc_s;
    step       = 2'd1;
    if (pend_q != 8'h00) begin
      step = add_q ? 2'd2 : 2'd0;
    end
    chain_sum = {1'b0, chain_q} + {14'h0000, step};
    sec_wrap  = osc_rise && chain_sum[15];
    min_wrap  = sec_wrap && (secs_q == 6'(SECS_PER_MIN - 1));
    coarse_ev = osc_rise && (chain_sum[15:8] != {1'b0, chain_q[14:8]});
    // Event rate set by coarse mode; trimming ignores backup
    trim_ev   = cfg_q.coarse_trim_enable ? coarse_ev : min_wrap;
    chain_d   = chain_q;
    secs_d    = secs_q;
    pend_d    = pend_q;
    add_d     = add_q;
    tick_d    = sec_wrap;
    if (osc_rise) begin
      chain_d = chain_sum[14:0];
      if (pend_q != 8'h00) begin
        pend_d = pend_q - 8'h01;
      end
    end
    if (sec_wrap) begin
      secs_d = min_wrap ? 6'd0 : secs_q + 6'd1;
    end
    // Zero step count starts no correction
    if (trim_ev && corr_q.trim_step_count != 7'h00) begin
      pend_d = {corr_q.trim_step_count, 1'b0};
      add_d  = corr_q.trim_add;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      osc_prev_q <= 1'b0;
      chain_q    <= 15'h0000;
      secs_q     <= 6'h00;
      pend_q     <= 8'h00;
      add_q      <= 1'b0;
      tick_q     <= 1'b0;
    end else begin
      osc_prev_q <= osc_prev_d;
      chain_q    <= chain_d;
      secs_q     <= secs_d;
      pend_q     <= pend_d;
      add_q      <= add_d;
      tick_q     <= tick_d;
    end
  end

  assign sec_tick_o = tick_q;

  // ---------------------------------------------------------------
  // Pin mode and level
  // ---------------------------------------------------------------
  pin_mode_t mode;
  logic      wave;
  logic      level;
  logic      drive;
  logic      pin_low_q, pin_low_d;

  always_comb begin
    // Square wave enable overrides the alarm enables
    if (cfg_q.square_wave_enable) begin
      mode = MODE_SQW;
    end else if (cfg_q.alarm0_enable || cfg_q.alarm1_enable) begin
      mode = MODE_ALARM;
    end else begin
      mode = MODE_GPO;
    end
    if (cfg_q.coarse_trim_enable) begin
      wave = chain_q[8];
    end else begin
      unique case (cfg_q.square_wave_freq_select)
        2'b00:   wave = chain_q[14];
        2'b01:   wave = chain_q[2];
        2'b10:   wave = chain_q[1];
        default: wave = osc_s;
      endcase
    end
    level = 1'b1;
    drive = 1'b0;
    unique case (mode)
      MODE_SQW: begin
        level = wave;
        drive = !backup_s;
      end
      MODE_ALARM: begin
        // Alarm output stays active on backup
        drive = 1'b1;
        if (cfg_q.alarm0_enable && cfg_q.alarm1_enable) begin
          level = pol_q ? (flag0_q || flag1_q) : !(flag0_q && flag1_q);
        end else if (cfg_q.alarm0_enable) begin
          level = pol_q ? flag0_q : !flag0_q;
        end else begin
          level = pol_q ? flag1_q : !flag1_q;
        end
      end
      MODE_GPO: begin
        level = cfg_q.gpo_level;
        drive = !backup_s;
      end
      default: begin
        level = 1'b1;
        drive = 1'b0;
      end
    endcase
    pin_low_d = drive && !level;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pin_low_q <= 1'b0;
    end else begin
      pin_low_q <= pin_low_d;
    end
  end

  // Open drain: only ever pulls low, pull-up gives the high level
  assign multi_function_pin_o    = 1'b0;
  assign multi_function_pin_oe_o = pin_low_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_trim_load;
    trim_ev && (corr_q.trim_step_count != 7'h00);
  endsequence

  sequence s_pend_loaded;
    ##1 (pend_q == {$past(corr_q.trim_step_count), 1'b0});
  endsequence

  chk_trim_load_count: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_trim_load |-> s_pend_loaded)
    else $error("trim pending count not twice the step count");

  chk_trim_zero_idle: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (corr_q.trim_step_count == 7'h00 && pend_q == 8'h00) |=> (pend_q == 8'h00))
    else $error("trim started with zero step count");

  chk_remove_stalls: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (osc_rise && pend_q != 8'h00 && !add_q) |=> $stable(chain_q))
    else $error("removed cycle still advanced the chain");

  chk_add_doubles: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (osc_rise && pend_q != 8'h00 && add_q) |=> (chain_q == $past(chain_q) + 15'h0002))
    else $error("added cycle did not double the advance");

  chk_single_alarm: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (mode == MODE_ALARM && cfg_q.alarm0_enable && !cfg_q.alarm1_enable)
      |=> (multi_function_pin_oe_o == ($past(pol_q) ? !$past(flag0_q) : $past(flag0_q))))
    else $error("single alarm pin level wrong");

  chk_dual_or: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (mode == MODE_ALARM && cfg_q.alarm0_enable && cfg_q.alarm1_enable && pol_q)
      |=> (multi_function_pin_oe_o == !($past(flag0_q) || $past(flag1_q))))
    else $error("dual alarm OR level wrong");

  chk_dual_nand: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (mode == MODE_ALARM && cfg_q.alarm0_enable && cfg_q.alarm1_enable && !pol_q)
      |=> (multi_function_pin_oe_o == ($past(flag0_q) && $past(flag1_q))))
    else $error("dual alarm NAND level wrong");

  chk_gpo_backup: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (mode == MODE_GPO && backup_s) |=> !multi_function_pin_oe_o)
    else $error("general purpose level driven on backup");

  chk_gpo_level: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (mode == MODE_GPO && !backup_s) |=> (multi_function_pin_oe_o == !$past(cfg_q.gpo_level)))
    else $error("general purpose level wrong");

  chk_flag_clear: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (wr_day0 && !alarm0_match_i) |=> !flag0_q)
    else $error("day write did not clear alarm flag");

  chk_flag_set_wins: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    alarm1_match_i |=> flag1_q)
    else $error("alarm match lost");

endmodule : rtc_output_pin_and_trim

// >>> test/rtc_far_side_model.sv
// Far side: free-running oscillator and pulled-up pin wire
`timescale 1ns/1ps
module rtc_far_side_model #(
  parameter real HALF_NS = 80.0
) (
  input  wire logic pin_data_i,
  input  wire logic pin_oe_i,
  output logic      osc_clk_o,
  output logic      pin_level_o
);
  // ---------------------------------------------------------------
  // Oscillator
  // ---------------------------------------------------------------
  // Crystal runs free, phase offset from system clock
  initial begin
    osc_clk_o = 1'b0;
    #3.3;
    forever #(HALF_NS) osc_clk_o = ~osc_clk_o;
  end
  // ---------------------------------------------------------------
  // Pin wire
  // ---------------------------------------------------------------
  // Open drain with pull-up: released pin reads high
  assign pin_level_o = pin_oe_i ? pin_data_i : 1'b1;
endmodule : rtc_far_side_model

// >>> test/rtc_output_pin_and_trim_tb_top.sv
// Self-checking testbench for the output pin and trim block
`timescale 1ns/1ps
module rtc_output_pin_and_trim_tb_top;
  import rtc_pin_trim_pkg::*;
  logic       clk_sys_i, reset_i, on_backup, m0, m1, wr, rd;
  logic       ext_en, pin_oe, pin_o, osc, pin_level, pol, f0, f1;
  logic [7:0] addr, wdata, rdata, cfg, day0, day1;
  logic [6:0] s;
  int         miscompares, total_checks, cycles, osc_rises;

  rtc_output_pin_and_trim #(.SECS_PER_MIN(1)) DUT (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .osc_clk_i(osc), .on_backup_i(on_backup),
    .alarm0_match_i(m0), .alarm1_match_i(m1), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .ext_clk_enable_o(ext_en), .sec_tick_o(), .multi_function_pin_o(pin_o),
    .multi_function_pin_oe_o(pin_oe));

  rtc_far_side_model far (
    .pin_data_i(pin_o), .pin_oe_i(pin_oe), .osc_clk_o(osc), .pin_level_o(pin_level));

  // ---------------------------------------------------------------
  // Clock, oscillator edge count and hang limit
  // ---------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge osc) osc_rises++;
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 100000) begin
      miscompares++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks and reference model
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // Write a register, update the model
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i); #1;
    wr = 1'b1; addr = a; wdata = d;
    @(posedge clk_sys_i); #1;
    wr = 1'b0;
    if (a == ADDR_PIN_CLOCK_CONFIG) cfg = d;
    if (a == ADDR_ALARM0_DAY || a == ADDR_ALARM1_DAY) pol = d[7];
    if (a == ADDR_ALARM0_DAY) begin
      day0 = d & 8'h77; f0 = 1'b0;
    end
    if (a == ADDR_ALARM1_DAY) begin
      day1 = d & 8'h77; f1 = 1'b0;
    end
  endtask : wrr

  // Read a register and compare
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk_sys_i); #1;
    rd = 1'b1; addr = a;
    @(posedge clk_sys_i); #1;
    rd = 1'b0;
    chk(n, {8'h00, rdata}, {8'h00, e});
  endtask : rdc

  task automatic pulse(input int which);
    @(posedge clk_sys_i); #1;
    if (which == 0) m0 = 1'b1;
    else m1 = 1'b1;
    @(posedge clk_sys_i); #1;
    m0 = 1'b0; m1 = 1'b0;
    if (which == 0) f0 = 1'b1;
    else f1 = 1'b1;
  endtask : pulse

  // Expected wire level, static modes
  function automatic logic exp_pin();
    if (cfg[6]) return 1'b1;
    if (cfg[5:4] == 2'b11) return pol ? (f0 | f1) : !(f0 & f1);
    if (cfg[4]) return pol ? f0 : !f0;
    if (cfg[5]) return pol ? f1 : !f1;
    return on_backup | cfg[7];
  endfunction : exp_pin

  task automatic pin_chk(input string n);
    repeat (5) @(posedge clk_sys_i);
    #1;
    chk(n, {15'h0, pin_level}, {15'h0, exp_pin()});
  endtask : pin_chk

  // Wait for the next pin wire rise
  task automatic rise();
    int n;
    n = 0;
    while (pin_level === 1'b1 && n < 20000) begin
      @(posedge clk_sys_i); n++;
    end
    while (pin_level !== 1'b1 && n < 40000) begin
      @(posedge clk_sys_i); n++;
    end
  endtask : rise

  // Square wave period in oscillator edges, after a partial one and one full period
  task automatic meas(input logic [7:0] t, input int e, c = 8'h74);
    int c0;
    wrr(ADDR_CLOCK_CORRECTION, t);
    wrr(ADDR_PIN_CLOCK_CONFIG, 8'(c));
    rise();
    rise();
    c0 = osc_rises;
    rise();
    chk("trim_period", 16'(osc_rises - c0), 16'(e));
  endtask : meas

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    reset_i = 1'b1; on_backup = 1'b0; m0 = 1'b0; m1 = 1'b0; wr = 1'b0; rd = 1'b0;
    addr = 8'h00; wdata = 8'h00; cfg = 8'h80; day0 = 8'h00; day1 = 8'h00;
    pol = 1'b0; f0 = 1'b0; f1 = 1'b0;
    void'($urandom(53157));
    repeat (20) @(posedge clk_sys_i);
    #1;
    reset_i = 1'b0;
    // Reset values, unmapped place, trim readback
    rdc(ADDR_PIN_CLOCK_CONFIG, RST_PIN_CLOCK_CONFIG, "config_reset");
    rdc(ADDR_CLOCK_CORRECTION, RST_CLOCK_CORRECTION, "trim_reset");
    rdc(ADDR_ALARM0_DAY, RST_ALARM_DAY, "day_reset");
    wrr(8'h30, 8'h5a);
    rdc(8'h30, 8'h00, "unmapped");
    wdata = 8'($urandom);
    wrr(ADDR_CLOCK_CORRECTION, wdata);
    rdc(ADDR_CLOCK_CORRECTION, wdata, "trim_rw");
    wrr(ADDR_PIN_CLOCK_CONFIG, 8'h08);
    chk("ext_clk", {15'h0, ext_en}, 16'h0001);
    $display("test registers done");
    // All alarm enables, polarities and flags; flag bit written as 1
    for (int en = 1; en < 4; en++) begin
      for (int p = 0; p < 2; p++) begin
        for (int f = 0; f < 4; f++) begin
          wrr(ADDR_PIN_CLOCK_CONFIG, {2'b10, en[1:0], 4'h0});
          wrr(ADDR_ALARM0_DAY, {p[0], 7'($urandom) | 7'h08});
          wrr(ADDR_ALARM1_DAY, {p[0], 7'($urandom) | 7'h08});
          if (f[0]) pulse(0);
          if (f[1]) pulse(1);
          pin_chk("pin_alarm");
          rdc(ADDR_ALARM0_DAY, day0 | {pol, 3'h0, f0, 3'h0}, "day_flag");
        end
      end
    end
    $display("test alarm pin done");
    // Backup supply: alarm drives, general purpose and square wave release
    wrr(ADDR_PIN_CLOCK_CONFIG, 8'h90);
    wrr(ADDR_ALARM0_DAY, 8'h80);
    on_backup = 1'b1;
    pin_chk("pin_alarm_backup");
    wrr(ADDR_PIN_CLOCK_CONFIG, 8'h00);
    pin_chk("pin_gpo_backup");
    wrr(ADDR_PIN_CLOCK_CONFIG, 8'h44);
    pin_chk("pin_sqw_backup");
    on_backup = 1'b0;
    wrr(ADDR_PIN_CLOCK_CONFIG, 8'h00);
    pin_chk("pin_gpo_low");
    wrr(ADDR_PIN_CLOCK_CONFIG, 8'h80);
    pin_chk("pin_gpo_high");
    $display("test pin modes done");
    // Host measures untrimmed rates, then loads direction and count
    for (int f = 1; f < 4; f++) meas(8'h00, f > 2 ? 1 : 16 >> f, 8'h70 + f);
    s = 7'(1 + $urandom % 31);
    meas(8'h80, 512);
    meas({1'b1, s}, 2 * (256 - 2 * int'(s)));
    meas({1'b0, s}, 2 * (256 + 2 * int'(s)));
    $display("test trim done");
    summarize();
  end
endmodule : rtc_output_pin_and_trim_tb_top
